// ===== hw/converter_fault_supervisor.sv
// fault protection and enable supervisor for an isolated converter
// ------------------------------------------------------------------
// Functional notes
// R1 - current limit indefinitely; shut down only if output falls below 4.0V
// R2 - auto-restart retries after overcurrent shutdown until fault clears
// R3 - overcurrent warn, fault limits and action are host-writable
// R4 - latched-off holds until input power cycle or 1 ms on/off toggle
// R5 - output overvoltage shuts down; auto-restart default; reprogrammable
// R6 - overtemperature shuts down; restarts after cooling about 25 C
// R7 - output enabled above input turn-on level, off below turn-off level
// R8 - host keeps turn-on level at least 2V above turn-off level
// R9 - input overvoltage shuts down; restarts 7V below the fault level
// R10 - primary enable has positive or negative factory polarity
// R11 - unused primary enable is tied to return or left open by system
// R12 - paralleled unit sees output present, lengthens delay, blocks reverse
// R13 - paralleled unit into pre-biased output lengthens its rise time
// R14 - system keeps load under half rating until all modules started
// R15 - control pins: enable+good default, trim+enable, trim+good
// R16 - secondary enable ignored until setup enables it, with polarity
// R17 - good flag on above good-on level, off on fault or below good-off
// R18 - good flag pin polarity positive by default, selectable negative
// R19 - output runs only when every enable, lockout and fault allows
// R20 - warning flags on current or temperature warn limit, no shutdown
// ------------------------------------------------------------------
`timescale 1ns/1ns
module converter_fault_supervisor
   import supervisor_pkg::*;
#(
   parameter int MS_DIV          = MS_CYCLES,
   parameter int OFF_HOLD_CYCLES = TOGGLE_CYCLES
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // measurements from the converter's own digitiser
   input  wire logic [15:0] vin_meas,
   input  wire logic [15:0] vout_meas,
   input  wire logic [15:0] iout_meas,
   input  wire logic [15:0] temp_meas,
   // host settings
   input  wire logic [15:0] overcurrent_warn_limit,
   input  wire logic [15:0] overcurrent_fault_limit,
   input  wire logic        overcurrent_fault_action,
   input  wire logic [15:0] output_overvolt_limit,
   input  wire logic        output_overvolt_action,
   input  wire logic [15:0] overtemp_warn_limit,
   input  wire logic [15:0] overtemp_fault_limit,
   input  wire logic        overtemp_fault_action,
   input  wire logic [15:0] input_on_level,
   input  wire logic [15:0] input_off_level,
   input  wire logic [15:0] input_overvolt_level,
   input  wire logic [15:0] good_on_level,
   input  wire logic [15:0] good_off_level,
   input  wire logic        good_flag_polarity,
   input  wire logic [1:0]  pin_function_select,
   input  wire logic [1:0]  secondary_enable_setup,
   // factory straps
   input  wire logic        primary_polarity_strap,
   input  wire logic        parallel_option,
   // pins
   input  wire logic        primary_enable_pin,
   input  wire logic        config_pin_one_in,
   output logic             config_pin_one_out,
   output logic             config_pin_one_oe_n,
   input  wire logic        config_pin_two_in,
   output logic             config_pin_two_out,
   output logic             config_pin_two_oe_n,
   // power stage control and status
   output logic             output_enable,
   output logic             reverse_block,
   output logic             rise_extended,
   output logic             current_limit_active,
   output logic             overcurrent_warn,
   output logic             overtemp_warn,
   output logic [3:0]       fault_status,
   output logic             input_ok,
   output logic             power_good
);

   // ----------------------------------------------------------------
   // pin synchronisers and strap capture
   // ----------------------------------------------------------------
   logic [2:0] pins_r;
   logic       pri_neg_r;
   logic       strap_done_r;

   pin_sync #(.W(3)) u_sync (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .pin_in     ({config_pin_two_in, config_pin_one_in,
                    primary_enable_pin}),
      .pin_sync_r (pins_r)
   );

   // strap is sampled once, on the first edge after reset release
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pri_neg_r    <= PRI_NEG_RESET;
         strap_done_r <= 1'b0;
      end else if (!strap_done_r) begin
         pri_neg_r    <= primary_polarity_strap; // see R10
         strap_done_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // enable sources
   // ----------------------------------------------------------------
   logic pri_on;
   logic sec_lvl;
   logic sec_routed;
   logic sec_on;
   logic any_fault;
   logic enable_all;
   logic [3:0] fault_r;

   assign pri_on = level_on(pins_r[0], pri_neg_r); // see R10

   // secondary enable lives on pin one or two, or nowhere
   always_comb begin
      sec_lvl    = pins_r[1];
      sec_routed = 1'b1;
      unique case (pin_function_select) // see R15
         PF_TRIM_ENA:  sec_lvl    = pins_r[2];
         PF_TRIM_GOOD: sec_routed = 1'b0;
         default:      sec_lvl    = pins_r[1];
      endcase
   end

   // ignored unless the setup turns it on; see R16
   assign sec_on = !(sec_routed && secondary_enable_setup[SEC_EN_BIT]) ||
                   level_on(sec_lvl, secondary_enable_setup[SEC_NEG_BIT]);

   assign any_fault  = |fault_r;
   assign enable_all = pri_on && sec_on && input_ok && !any_fault; // see R19

   // ----------------------------------------------------------------
   // millisecond divider and on/off toggle detector
   // ----------------------------------------------------------------
   logic [15:0] ms_div_r;
   logic        ms_tick_r;
   logic [15:0] off_cnt_r;
   logic        toggle_r;
   logic        latch_reset;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ms_div_r  <= '0;
         ms_tick_r <= 1'b0;
      end else if (ms_div_r == 16'(MS_DIV - 1)) begin
         ms_div_r  <= '0;
         ms_tick_r <= 1'b1;
      end else begin
         ms_div_r  <= ms_div_r + 16'h0001;
         ms_tick_r <= 1'b0;
      end
   end

   // one pulse once the primary enable has been off for the hold time
   always_ff @(posedge ref_clk) begin
      if (rst || pri_on) begin
         off_cnt_r <= '0;
         toggle_r  <= 1'b0;
      end else if (off_cnt_r != 16'(OFF_HOLD_CYCLES)) begin
         off_cnt_r <= off_cnt_r + 16'h0001;
         toggle_r  <= (off_cnt_r == 16'(OFF_HOLD_CYCLES - 1));
      end else begin
         toggle_r  <= 1'b0;
      end
   end

   // input lockout stands in for an input power cycle
   assign latch_reset = toggle_r || !input_ok; // see R4

   // ----------------------------------------------------------------
   // input lockout, warnings and current limit
   // ----------------------------------------------------------------
   // hysteresis width is the host's job; equal levels just chatter
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         input_ok <= 1'b0;
      end else if (vin_meas < input_off_level) begin
         input_ok <= 1'b0; // see R7
      end else if (vin_meas > input_on_level) begin
         input_ok <= 1'b1; // see R7
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         current_limit_active <= 1'b0;
         overcurrent_warn     <= 1'b0;
         overtemp_warn        <= 1'b0;
      end else begin
         current_limit_active <= iout_meas > overcurrent_fault_limit; // see R3
         overcurrent_warn <= iout_meas > overcurrent_warn_limit; // see R20
         overtemp_warn    <= temp_meas > overtemp_warn_limit;    // see R20
      end
   end

   // ----------------------------------------------------------------
   // protection channels
   // ----------------------------------------------------------------
   seq_state_t  seq_r;
   logic [7:0]  hic_r;
   logic        hiccup_done;
   logic        oc_trip;
   logic [3:0]  trip;
   logic [3:0]  clear_ok;
   logic [3:0]  latched;

   // overload only trips once the output has collapsed; see R1
   assign oc_trip = seq_r == SEQ_RUN &&
                    iout_meas > overcurrent_fault_limit &&
                    vout_meas < VOUT_COLLAPSE;
   assign trip = {vin_meas > input_overvolt_level,        // see R9
                  temp_meas > overtemp_fault_limit,        // see R6
                  vout_meas > output_overvolt_limit,       // see R5
                  oc_trip};
   assign hiccup_done = hic_r >= HICCUP_MS;
   assign clear_ok = {
      {1'b0, vin_meas} + VIN_OV_HYST <= {1'b0, input_overvolt_level},
      {1'b0, temp_meas} + OT_HYST <= {1'b0, overtemp_fault_limit},
      hiccup_done, hiccup_done}; // see R2
   assign latched = {1'b0, overtemp_fault_action,
                     output_overvolt_action, overcurrent_fault_action};

   // retry timer runs while an overcurrent or overvoltage holds off
   always_ff @(posedge ref_clk) begin
      if (rst || !(fault_r[FLT_OC] || fault_r[FLT_OV]) || hiccup_done) begin
         hic_r <= '0;
      end else if (ms_tick_r) begin
         hic_r <= hic_r + 8'h01;
      end
   end

   generate
      for (genvar i = 0; i < NUM_FAULTS; i++) begin : g_flt
         fault_channel u_chan (
            .ref_clk      (ref_clk),
            .rst          (rst),
            .trip         (trip[i]),
            .clear_ok     (clear_ok[i]),
            .latched_mode (latched[i] == ACTION_LATCH),
            .latch_reset  (latch_reset),
            .fault_r      (fault_r[i])
         );
      end
   endgenerate

   assign fault_status = fault_r;

   // ----------------------------------------------------------------
   // start-up sequencer
   // ----------------------------------------------------------------
   logic [7:0] time_r;
   logic       ext_delay_r;
   logic       ext_rise_r;
   logic       prebias;

   assign prebias = parallel_option && vout_meas > VOUT_PREBIAS;

   // any enable source dropping aborts the start at once
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         seq_r       <= SEQ_OFF;
         time_r      <= '0;
         ext_delay_r <= 1'b0;
         ext_rise_r  <= 1'b0;
      end else if (!enable_all) begin
         seq_r  <= SEQ_OFF; // see R19
         time_r <= '0;
      end else begin
         unique case (seq_r)
            SEQ_OFF: begin
               seq_r       <= SEQ_DELAY;
               time_r      <= '0;
               ext_delay_r <= prebias; // see R12
            end
            SEQ_DELAY: begin
               if (time_r >= (ext_delay_r ? TDELAY_EXT_MS : TDELAY_MS)) begin
                  seq_r      <= SEQ_RISE;
                  time_r     <= '0;
                  ext_rise_r <= prebias; // see R13
               end else if (ms_tick_r) begin
                  time_r <= time_r + 8'h01;
               end
            end
            SEQ_RISE: begin
               if (time_r >= (ext_rise_r ? TRISE_EXT_MS : TRISE_MS)) begin
                  seq_r <= SEQ_RUN;
               end else if (ms_tick_r) begin
                  time_r <= time_r + 8'h01;
               end
            end
            SEQ_RUN: begin
               seq_r <= SEQ_RUN;
            end
         endcase
      end
   end

   // reverse blocking stays on until the rise is done; see R12
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         output_enable <= 1'b0;
         reverse_block <= 1'b0;
         rise_extended <= 1'b0;
      end else begin
         output_enable <= enable_all &&
                          (seq_r == SEQ_RISE || seq_r == SEQ_RUN);
         reverse_block <= parallel_option && seq_r != SEQ_RUN;
         rise_extended <= seq_r == SEQ_RISE && ext_rise_r;
      end
   end

   // ----------------------------------------------------------------
   // good flag and control pin drive
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         power_good <= 1'b0;
      end else if (any_fault || seq_r != SEQ_RUN ||
                   vout_meas < good_off_level) begin
         power_good <= 1'b0; // see R17
      end else if (vout_meas > good_on_level) begin
         power_good <= 1'b1; // see R17
      end
   end

   // open drain: released reads high through the pull-up
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         config_pin_two_oe_n <= 1'b1;
      end else if (pin_function_select == PF_TRIM_ENA) begin
         config_pin_two_oe_n <= 1'b1; // see R15
      end else begin
         config_pin_two_oe_n <= power_good ^ good_flag_polarity; // see R18
      end
   end

   // pin one is trim or an enable input, never driven
   assign config_pin_one_out  = 1'b0;
   assign config_pin_one_oe_n = 1'b1;
   assign config_pin_two_out  = 1'b0;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_oc_limit_only: assert property ( // see R1
      !fault_r[FLT_OC] && vout_meas >= VOUT_COLLAPSE |=> !fault_r[FLT_OC])
      else $error("overcurrent shutdown without output collapse");
   a_oc_trip_now: assert property ( // see R1
      oc_trip |=> fault_r[FLT_OC] ##1 !output_enable && seq_r == SEQ_OFF)
      else $error("collapsed overload did not shut down");
   a_oc_retry: assert property ( // see R2
      fault_r[FLT_OC] && overcurrent_fault_action != ACTION_LATCH &&
      hiccup_done && !oc_trip |=> !fault_r[FLT_OC])
      else $error("auto-restart did not retry");
   a_latch_holds: assert property ( // see R4
      fault_r[FLT_OV] && output_overvolt_action == ACTION_LATCH &&
      !latch_reset && !trip[FLT_OV] |=> fault_r[FLT_OV])
      else $error("latched overvoltage released early");
   a_ot_cooldown: assert property ( // see R6
      fault_r[FLT_OT] && overtemp_fault_action != ACTION_LATCH &&
      temp_meas > overtemp_fault_limit - 16'(OT_HYST) |=> fault_r[FLT_OT])
      else $error("overtemperature restarted before cooling");
   a_uvlo_off: assert property ( // see R7
      vin_meas < input_off_level |=> !input_ok ##1 !output_enable)
      else $error("output not disabled below turn-off level");
   a_vin_ov_trip: assert property ( // see R9
      vin_meas > input_overvolt_level |=> fault_r[FLT_VIN])
      else $error("input overvoltage not caught");
   a_enable_gate: assert property ( // see R19
      !pri_on |=> seq_r == SEQ_OFF ##1 !output_enable)
      else $error("output ran with primary enable off");
   a_sec_enable: assert property ( // see R16
      !sec_on |=> seq_r == SEQ_OFF)
      else $error("secondary enable ignored while active");
   a_ext_delay: assert property ( // see R12
      seq_r == SEQ_DELAY && ext_delay_r && time_r < TDELAY_EXT_MS
      |=> seq_r != SEQ_RISE)
      else $error("extended delay cut short");
   a_good_drop: assert property ( // see R17
      any_fault |=> !power_good ##1 config_pin_two_oe_n == good_flag_polarity
      || pin_function_select == PF_TRIM_ENA || $changed(good_flag_polarity))
      else $error("good flag held through a fault");

   c_oc_trip:   cover property (oc_trip ##1 fault_r[FLT_OC]);
   c_oc_retry:  cover property (fault_r[FLT_OC] ##1 !fault_r[FLT_OC]);
   c_ext_start: cover property (seq_r == SEQ_RISE && ext_rise_r);
   c_good_up:   cover property ($rose(power_good));

endmodule

// ===== hw/fault_channel.sv
// one protection channel: trip, auto-restart or latched-off hold
`timescale 1ns/1ns
module fault_channel
   import supervisor_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // conditions
   input  wire logic trip,
   input  wire logic clear_ok,
   input  wire logic latched_mode,
   input  wire logic latch_reset,
   // state
   output logic      fault_r
);

   // trip wins over any clear arriving in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fault_r <= 1'b0;
      end else if (trip) begin
         fault_r <= 1'b1;
      end else if (latched_mode ? latch_reset : clear_ok) begin
         fault_r <= 1'b0;
      end
   end

endmodule

// ===== hw/pin_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module pin_sync
   import supervisor_pkg::*;
#(
   parameter int W = 3
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst,
   // levels
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_sync_r
);

   logic [W-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_r     <= '0;
         pin_sync_r <= '0;
      end else begin
         meta_r     <= pin_in;
         pin_sync_r <= meta_r;
      end
   end

endmodule

// ===== shared/supervisor_pkg.sv
// constants shared by the converter fault supervisor
package supervisor_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 100;
   localparam int MS_TIME_NS     = 1000000;
   localparam int MS_CYCLES      = MS_TIME_NS / CLK_PERIOD_NS;
   localparam int TOGGLE_TIME_NS = 1000000;
   localparam int TOGGLE_CYCLES  = TOGGLE_TIME_NS / CLK_PERIOD_NS;
   localparam logic [7:0] TDELAY_MS     = 8'h0a;
   localparam logic [7:0] TDELAY_EXT_MS = 8'h1e;
   localparam logic [7:0] TRISE_MS      = 8'h05;
   localparam logic [7:0] TRISE_EXT_MS  = 8'h0f;
   localparam logic [7:0] HICCUP_MS     = 8'h64;

   // ----------------------------------------------------------------
   // measurement scaling and fixed thresholds
   // ----------------------------------------------------------------
   localparam int MEAS_W          = 16;
   localparam int VOUT_LSB_PER_V  = 4096;
   localparam int VOUT_COLLAPSE_MV = 4000;
   localparam logic [15:0] VOUT_COLLAPSE =
      16'(VOUT_COLLAPSE_MV * VOUT_LSB_PER_V / 1000);
   localparam int PREBIAS_MV      = 500;
   localparam logic [15:0] VOUT_PREBIAS =
      16'(PREBIAS_MV * VOUT_LSB_PER_V / 1000);
   localparam int VIN_LSB_MV      = 125;
   localparam int VIN_OV_HYST_MV  = 7000;
   localparam logic [16:0] VIN_OV_HYST = 17'(VIN_OV_HYST_MV / VIN_LSB_MV);
   localparam int TEMP_LSB_MC     = 250;
   localparam int OT_HYST_MC      = 25000;
   localparam logic [16:0] OT_HYST = 17'(OT_HYST_MC / TEMP_LSB_MC);

   // ----------------------------------------------------------------
   // fault channels, actions, pin functions, reset values
   // ----------------------------------------------------------------
   localparam int NUM_FAULTS = 4;
   localparam int FLT_OC     = 0;
   localparam int FLT_OV     = 1;
   localparam int FLT_OT     = 2;
   localparam int FLT_VIN    = 3;
   localparam logic ACTION_LATCH = 1'b1;
   localparam logic [1:0] PF_ENA_GOOD  = 2'h0;
   localparam logic [1:0] PF_TRIM_ENA  = 2'h1;
   localparam logic [1:0] PF_TRIM_GOOD = 2'h2;
   localparam int SEC_EN_BIT  = 0;
   localparam int SEC_NEG_BIT = 1;
   localparam logic PRI_NEG_RESET = 1'b1;

   typedef enum logic [1:0] {SEQ_OFF, SEQ_DELAY, SEQ_RISE, SEQ_RUN}
      seq_state_t;

   // enable level seen through a polarity choice (1 = negative)
   function automatic logic level_on(input logic lvl, input logic neg);
      return lvl ^ neg;
   endfunction

endpackage

// ===== tb/converter_stage_model.sv
// behavioural power stage and host levels facing the supervisor
`timescale 1ns/1ns
module converter_stage_model (
   // clock and control
   input  wire logic        ref_clk,
   input  wire logic        output_enable,
   input  wire logic [1:0]  vout_mode,
   // measurement and host levels
   output logic      [15:0] vout_meas,
   output logic      [15:0] input_on_level,
   output logic      [15:0] input_off_level
);
   // on at 40 v, off at 34 v: the 6 v gap keeps the lockout stable
   assign input_on_level  = 16'h0140;
   assign input_off_level = 16'h0110;
   // output follows the enable; modes force collapse, overvolt, prebias
   always @(negedge ref_clk) begin
      case (vout_mode)
         2'h1:    vout_meas <= 16'h2000;
         2'h2:    vout_meas <= 16'hf000;
         default: vout_meas <= output_enable ? 16'hc000 :
                  ((vout_mode == 2'h3) ? 16'h1000 : 16'h0000);
      endcase
   end
endmodule

// ===== tb/test_converter_fault_supervisor.sv
// self-checking bench for the converter fault supervisor
`timescale 1ns/1ns
module test_converter_fault_supervisor;
   import supervisor_pkg::*;
   // ------------------------------------------------
   // signals and helpers
   // ------------------------------------------------
   logic        ref_clk, rst, pin1_drv;
   logic [15:0] vin_meas, vout_meas, iout_meas, temp_meas;
   logic [15:0] overcurrent_warn_limit, overcurrent_fault_limit;
   logic [15:0] output_overvolt_limit, overtemp_warn_limit;
   logic [15:0] overtemp_fault_limit, input_overvolt_level;
   logic [15:0] input_on_level, input_off_level;
   logic [15:0] good_on_level, good_off_level;
   logic        overcurrent_fault_action, output_overvolt_action;
   logic        overtemp_fault_action, good_flag_polarity;
   logic [1:0]  pin_function_select, secondary_enable_setup, vout_mode;
   logic        primary_polarity_strap, parallel_option;
   logic        primary_enable_pin, config_pin_one_in, config_pin_two_in;
   logic        config_pin_one_out, config_pin_one_oe_n;
   logic        config_pin_two_out, config_pin_two_oe_n;
   logic        output_enable, reverse_block, rise_extended;
   logic        current_limit_active, overcurrent_warn, overtemp_warn;
   logic [3:0]  fault_status;
   logic        input_ok, power_good;
   logic [12:0] obs, m, e;
   logic [25:0] notes[$];
   logic [15:0] seed = 16'hb41b;
   int          n_fail = 0;
   int          samples_checked = 0;
   event        note_ev;
   localparam logic [12:0] G2 = 13'h0001, EN = 13'h0002, RB = 13'h0004;
   localparam logic [12:0] RX = 13'h0008, CL = 13'h0010, OW = 13'h0020;
   localparam logic [12:0] TW = 13'h0040, F0 = 13'h0080, F1 = 13'h0100;
   localparam logic [12:0] F2 = 13'h0200, F3 = 13'h0400, IOK = 13'h0800;
   localparam logic [12:0] GD = 13'h1000;

   converter_fault_supervisor #(.MS_DIV(10), .OFF_HOLD_CYCLES(20)) u_dut (.*);
   converter_stage_model u_stage (.*);

   // open-drain pins: pull-up wins unless a party pulls low
   assign config_pin_one_in = pin1_drv & (config_pin_one_oe_n |
                                          config_pin_one_out);
   assign config_pin_two_in = config_pin_two_oe_n | config_pin_two_out;
   assign obs = {power_good, input_ok, fault_status, overtemp_warn,
                 overcurrent_warn, current_limit_active, rise_extended,
                 reverse_block, output_enable, config_pin_two_in};

   // free-running 10 mhz clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // oldest note is compared against the outputs when it is posted
   always @(note_ev) begin
      {m, e} = notes.pop_front();
      samples_checked++;
      if ((obs & m) !== e) begin
         n_fail++;
         $display("FAIL %0t obs %h mask %h exp %h", $time, obs, m, e);
      end
   end

   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 7);
      seed = seed ^ (seed >> 9);
      seed = seed ^ (seed << 8);
      return seed % 16'h00c8; // below half rating
   endfunction

   task automatic chk(input logic [12:0] mk, input logic [12:0] ex);
      notes.push_back({mk, ex});
      -> note_ev;
      #1;
   endtask

   // bounded wait: gives up after n cycles and lets the compare fail
   task automatic wait_for(input logic [12:0] mk, input logic [12:0] ex,
                           input int n);
      for (int i = 0; i < n && (obs & mk) !== ex; i++) @(negedge ref_clk);
      chk(mk, ex);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic report_and_stop();
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // hang guard: about four times the expected run
   initial begin
      #2000000;
      n_fail++;
      report_and_stop();
   end

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   initial begin
      rst = 1'b1;
      {vin_meas, iout_meas, temp_meas} = {16'h0180, 16'h0000, 16'h00c8};
      {overcurrent_warn_limit, overcurrent_fault_limit} = {16'h0140, 16'h0190};
      {output_overvolt_limit, overtemp_warn_limit} = {16'he000, 16'h0190};
      {overtemp_fault_limit, input_overvolt_level} = {16'h01e0, 16'h0258};
      {good_on_level, good_off_level} = {16'hb000, 16'ha000};
      {overcurrent_fault_action, output_overvolt_action} = 2'h0;
      {overtemp_fault_action, good_flag_polarity, parallel_option} = 3'h0;
      {pin_function_select, secondary_enable_setup, vout_mode} = 6'h00;
      {primary_polarity_strap, primary_enable_pin, pin1_drv} = 3'h5;
      cyc(3);
      chk(13'h1fff, G2);
      cyc(2);
      rst = 1'b0;
      iout_meas = rnd();
      wait_for(GD | EN | G2 | IOK, GD | EN | G2 | IOK, 400);
      // warnings raise flags only; warn limit rewritten on the fly
      iout_meas = 16'h0150;
      cyc(2);
      chk(OW | CL | EN, OW | EN);
      temp_meas = 16'h01a0;
      cyc(2);
      chk(TW | F2 | EN, TW | EN);
      {temp_meas, overcurrent_warn_limit} = {16'h00c8, 16'h0160};
      cyc(2);
      chk(OW | TW, 0);
      // overload limits, then collapse shuts down and retries
      iout_meas = 16'h01a0;
      cyc(3);
      chk(CL | F0 | EN, CL | EN);
      vout_mode = 2'h1;
      wait_for(F0 | EN, F0, 5);
      wait_for(EN, EN, 1400);
      wait_for(F0 | EN, F0, 200);
      {vout_mode, iout_meas} = {2'h0, rnd()};
      wait_for(GD | F0, GD, 1600);
      // latched overvoltage holds until the primary pin is toggled
      {output_overvolt_action, vout_mode} = {1'b1, 2'h2};
      wait_for(F1 | EN, F1, 5);
      vout_mode = 2'h0;
      cyc(1200);
      chk(F1 | EN, F1);
      primary_enable_pin = 1'b1;
      cyc(25);
      {primary_enable_pin, output_overvolt_action} = 2'h0;
      wait_for(F1 | GD, GD, 400);
      // overtemperature clears only after cooling by 25 degrees
      temp_meas = 16'h01f0;
      wait_for(F2 | EN, F2, 5);
      temp_meas = 16'h0190;
      cyc(10);
      chk(F2, F2);
      temp_meas = 16'h017c;
      wait_for(F2, 0, 3);
      // input overvoltage clears 7 v below the level
      vin_meas = 16'h0260;
      wait_for(F3 | EN, F3, 5);
      vin_meas = 16'h0221;
      cyc(10);
      chk(F3, F3);
      vin_meas = 16'h0220;
      wait_for(F3, 0, 3);
      // undervoltage lockout with hysteresis
      vin_meas = 16'h0100;
      wait_for(IOK | EN, 0, 5);
      vin_meas = 16'h0120;
      cyc(5);
      chk(IOK, 0);
      vin_meas = 16'h0180;
      wait_for(GD | IOK, GD | IOK, 400);
      // secondary enable: ignored by default, then honoured
      pin1_drv = 1'b0;
      cyc(4);
      chk(EN, EN);
      secondary_enable_setup = 2'h1;
      wait_for(EN | GD, 0, 6);
      pin_function_select = 2'h2;
      wait_for(EN, EN, 400);
      {pin_function_select, secondary_enable_setup} = 4'h3;
      cyc(4);
      chk(EN, EN);
      pin1_drv = 1'b1;
      wait_for(EN, 0, 6);
      secondary_enable_setup = 2'h0;
      wait_for(GD | G2, GD | G2, 400);
      good_flag_polarity = 1'b1;
      cyc(3);
      chk(G2, 0);
      pin_function_select = 2'h1;
      cyc(3);
      chk(G2, G2);
      secondary_enable_setup = 2'h3;
      wait_for(EN, 0, 6);
      {pin_function_select, good_flag_polarity, secondary_enable_setup} = 5'h00;
      // paralleled start into a prebiased output
      {parallel_option, vout_mode, primary_enable_pin} = 4'hf;
      wait_for(EN | RB, RB, 30);
      primary_enable_pin = 1'b0;
      wait_for(RX | EN | RB, RX | EN | RB, 450);
      wait_for(RB | GD, GD, 300);
      // fresh reset with the positive strap: pin high runs the output
      {rst, primary_polarity_strap, primary_enable_pin} = 3'h5;
      cyc(5);
      rst = 1'b0;
      wait_for(EN, EN, 600);
      primary_enable_pin = 1'b0;
      wait_for(EN, 0, 6);
      cyc(2);
      report_and_stop();
   end
endmodule
